// ===== bench/prs_host.sv
`timescale 1ns/1ns
module prs_host (
  output logic cs_n,
  output logic sclk,
  output logic sin,
  output logic ps,
  input  logic serial_out_pin,
  input  logic sda_out,
  input  logic sda_oe
);
  logic serial_in_pin   = 1'b0;
  logic m_low = 1'b0;
  logic sda;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    ps   = 1'b0;
  end
  // The data wire has a pull-up, so it is low whenever either side pulls.
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  assign sin = ps ? sda : serial_in_pin;
  // Unused data bits toggle so a stale level is never mistaken for data.
  task automatic spi_xfer(input logic [7:0] cmd, input int nout,
                          input logic mode3, output logic [23:0] rd);
    int i;
    rd = 24'h000000;
    sclk = mode3;
    #40 cs_n = 1'b0;
    #40;
    for (i = 0; i < 8 + nout; i++) begin
      if (mode3) sclk = 1'b0;
      serial_in_pin = (i < 8) ? cmd[7 - i] : ~serial_in_pin;
      #40 sclk = 1'b1;
      if (i >= 8) rd = {rd[22:0], serial_out_pin};
      #40;
      if (!mode3) sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    #40;
  endtask
  task automatic i2c_start;
    m_low = 1'b0;
    sclk  = 1'b1;
    #40 m_low = 1'b1;
    #40 sclk = 1'b0;
  endtask
  task automatic i2c_stop;
    #20 m_low = 1'b1;
    #20 sclk = 1'b1;
    #40 m_low = 1'b0;
    #40;
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    #20 m_low = ~b;
    #20 sclk = 1'b1;
    #40 r = sda;
    sclk = 1'b0;
  endtask
  task automatic i2c_wr(input logic [7:0] d, output logic ack_n);
    int   i;
    logic r;
    for (i = 0; i < 8; i++) i2c_bit(d[7 - i], r);
    i2c_bit(1'b1, ack_n);
  endtask
  // The last byte is refused so the device lets go of the wire.
  task automatic i2c_rd(input int n, output logic [23:0] rd);
    int   i;
    logic r;
    rd = 24'h000000;
    for (i = 0; i < 8 * n; i++) begin
      i2c_bit(1'b1, r);
      rd = {rd[22:0], r};
      if (i % 8 == 7) i2c_bit(i == 8 * n - 1, r);
    end
  endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
`include "prs_cfg.svh"
module testbench;
  localparam int DEPTH = 4;
  logic                                  ref_clk    = 1'b0;
  logic                                  sys_rst    = 1'b1;
  logic                                  cs_n, sclk, sin, ps;
  logic                                  serial_out_pin, sda_out, sda_oe;
  logic [`PRS_CAL_W*`PRS_CAL_N-1:0]      cal_rom;
  logic                                  conv_start, conv_ready, busy;
  logic                                  conv_valid = 1'b0;
  logic                                  eng_on     = 1'b1;
  logic [23:0]                           conv_data  = 24'h000000;
  logic [23:0]                           last_word  = 24'h000000;
  logic [23:0]                           rd;
  logic                                  ack_n, ack2;
  prs_pkg::prs_conv_req_t                conv_req, req_seen;
  int miscompares = 0;
  int check_count = 0;
  int starts      = 0;
  int eng_dly     = 100;
  int cycles      = 0;

  always #5 ref_clk = ~ref_clk;

  function automatic logic [15:0] cal_word(input int i);
    return 16'h1c2d + 16'(i) * 16'h2111;
  endfunction
  initial begin
    for (int i = 0; i < 8; i++) cal_rom[16 * i +: 16] = cal_word(i);
  end

  prs_host i_host (
    .cs_n    (cs_n),
    .sclk    (sclk),
    .sin     (sin),
    .ps      (ps),
    .serial_out_pin     (serial_out_pin),
    .sda_out (sda_out),
    .sda_oe  (sda_oe)
  );
  prs_port #(.FIFO_DEPTH(DEPTH)) i_dut (
    .REF_CLK             (ref_clk),
    .SYS_RST             (sys_rst),
    .PROTOCOL_SELECT_PIN (ps),
    .CHIP_SELECT_N_PIN   (cs_n),
    .SCLK_PIN            (sclk),
    .SERIAL_IN_PIN       (sin),
    .SERIAL_OUT_PIN      (serial_out_pin),
    .SDA_OUT             (sda_out),
    .SDA_OE              (sda_oe),
    .CAL_ROM             (cal_rom),
    .CONV_START          (conv_start),
    .CONV_REQ            (conv_req),
    .CONV_VALID          (conv_valid),
    .CONV_READY          (conv_ready),
    .CONV_DATA           (conv_data),
    .BUSY                (busy)
  );

  // Conversion engine: answers each start with one word after a delay.
  always begin
    @(posedge ref_clk);
    #1;
    if (conv_start === 1'b1) begin
      req_seen = conv_req;
      starts++;
      if (eng_on) begin
        repeat (eng_dly) @(posedge ref_clk);
        #1 conv_data = 24'h3c5a00 + 24'(starts);
        conv_valid = 1'b1;
        last_word  = conv_data;
        while (conv_ready !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk);
        #1 conv_valid = 1'b0;
      end
    end
  end

  task automatic chk(input logic [23:0] seen, exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(busy, 1'b0, "busy stuck");
  endtask

  task t_cal;
    i_host.spi_xfer(8'ha4, 16, 1'b0, rd);
    chk(rd, 24'h000000, "cal before reset");
    i_host.spi_xfer(`PRS_CMD_RESET, 0, 1'b1, rd);
    for (int i = 0; i < 8; i++) begin
      i_host.spi_xfer(8'ha0 | 8'(2 * i), 16, i[0], rd);
      chk(rd, {8'h00, cal_word(i)}, "cal word");
    end
    i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, 1'b0, rd);
    chk(rd, 24'h000000, "read without conversion");
    $display("test cal done");
  endtask

  task t_conv;
    prs_pkg::prs_conv_req_t exp_req;
    for (int k = 0; k < 10; k++) begin
      exp_req = {k >= 5, 3'(k % 5)};
      i_host.spi_xfer(8'h40 | {3'h0, exp_req, 1'b0}, 0, k[0], rd);
      chk(busy, 1'b1, "busy after start");
      chk(req_seen, exp_req, "request");
      wait_idle;
      i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, k[0], rd);
      chk(rd, last_word, "result");
      i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, ~k[0], rd);
      chk(rd, 24'h000000, "repeat read");
    end
    $display("test conv done");
  endtask

  task t_corrupt;
    eng_dly = 200;
    i_host.spi_xfer(8'h58, 0, 1'b0, rd);
    i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, 1'b0, rd);
    chk(rd, 24'h000000, "read while busy");
    wait_idle;
    i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, 1'b1, rd);
    chk(rd, ~last_word, "corrupted result");
    i_host.spi_xfer(8'h50, 0, 1'b1, rd);
    wait_idle;
    i_host.spi_xfer(`PRS_CMD_RESET, 0, 1'b0, rd);
    i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, 1'b0, rd);
    chk(rd, 24'h000000, "read after reset");
    eng_dly = 100;
    $display("test corrupt done");
  endtask

  task t_fifo;
    int n;
    eng_on = 1'b0;
    for (n = 0; n < DEPTH + 2; n++) begin
      @(posedge ref_clk);
      #1;
      if (conv_ready !== 1'b1) break;
      conv_data  = 24'hf00010 + 24'(n);
      conv_valid = 1'b1;
      @(posedge ref_clk);
      #1 conv_valid = 1'b0;
    end
    chk(24'(n), 24'(DEPTH), "words taken");
    chk(conv_ready, 1'b0, "full refuses");
    for (n = 0; n < DEPTH; n++) begin
      i_host.spi_xfer(8'h46, 0, 1'b0, rd);
      wait_idle;
      i_host.spi_xfer(`PRS_CMD_ADC_READ, 24, 1'b1, rd);
      chk(rd, 24'hf00010 + 24'(n), "queued word");
    end
    chk(conv_ready, 1'b1, "drained");
    eng_on = 1'b1;
    $display("test fifo done");
  endtask

  // A read is two messages: the command byte, then the answer bytes.
  task rd_i2c(input logic [7:0] c, input int n);
    i_host.i2c_start;
    i_host.i2c_wr(8'hee, ack_n);
    i_host.i2c_wr(c, ack2);
    i_host.i2c_stop;
    chk({ack_n, ack2}, 2'b00, "read command acks");
    i_host.i2c_start;
    i_host.i2c_wr(8'hef, ack_n);
    chk(ack_n, 1'b0, "read address");
    i_host.i2c_rd(n, rd);
    i_host.i2c_stop;
  endtask

  task t_i2c;
    i_host.ps   = 1'b1;
    i_host.cs_n = 1'b1;
    eng_dly     = 300;
    repeat (8) @(posedge ref_clk);
    #1;
    i_host.i2c_start;
    i_host.i2c_wr(8'hec, ack_n);
    chk(ack_n, 1'b0, "address with select high");
    i_host.i2c_stop;
    i_host.cs_n = 1'b0;
    #40;
    i_host.i2c_start;
    i_host.i2c_wr(8'hec, ack_n);
    chk(ack_n, 1'b1, "foreign address");
    i_host.i2c_stop;
    i_host.i2c_start;
    i_host.i2c_wr(8'hee, ack_n);
    i_host.i2c_wr(8'h48, ack2);
    i_host.i2c_stop;
    chk({ack_n, ack2}, 2'b00, "command acks");
    chk(req_seen, 4'h4, "i2c request");
    i_host.i2c_start;
    i_host.i2c_wr(8'hef, ack_n);
    chk(ack_n, 1'b1, "read while busy");
    i_host.i2c_stop;
    wait_idle;
    rd_i2c(`PRS_CMD_ADC_READ, 3);
    chk(rd, last_word, "i2c result");
    rd_i2c(8'ha6, 2);
    chk(rd, {8'h00, cal_word(3)}, "i2c cal word");
    i_host.i2c_start;
    i_host.i2c_wr(8'hee, ack_n);
    i_host.i2c_wr(`PRS_CMD_RESET, ack2);
    i_host.i2c_stop;
    chk(ack2, 1'b0, "reset ack");
    rd_i2c(`PRS_CMD_ADC_READ, 3);
    chk(rd, 24'h000000, "read after i2c reset");
    $display("test i2c done");
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      $display("wrong value at %0t: run too long", $time);
      tally_and_finish;
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    t_cal;
    t_conv;
    t_corrupt;
    t_fifo;
    t_i2c;
    tally_and_finish;
  end
endmodule

// ===== hw/prs_fifo.sv
`timescale 1ns/1ns
module prs_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) ||
                     (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ===== hw/prs_port.sv
`timescale 1ns/1ns
`include "prs_cfg.svh"
// How it works
// [RL1] Host sends reset once after power-up so calibration words get loaded.
// [RL2] Reset command returns conversion, result and calibration to idle.
// [RL3] SPI takes commands in mode 0 or mode 3, by idle clock level.
// [RL4] Conversion command starts pressure or temperature; chip select may rise.
// [RL5] Result-read shifts the finished result out most significant bit first.
// [RL6] Result-read with no conversion, or repeated, returns all zeros.
// [RL7] Result-read during conversion returns zero; conversion continues, corrupted.
// [RL8] Host must not start a conversion while one is running.
// [RL9] Host reads calibration memory once after reset.
// [RL10] Calibration memory is eight 16-bit words, 128 bits.
// [RL11] Word 0 factory setup, words 1-6 coefficients, word 7 serial and CRC.
// [RL12] Calibration read: 8-bit command, 16-bit answer, MSB first.
// [RL13] Every I2C message opens with START and closes with STOP.
// [RL14] I2C address is 111011 then inverted chip select, then R/W.
// [RL15] I2C reset accepted at any time; stuck SDA needs power-on reset.
// [RL16] After an I2C conversion command the device stays busy until done.
// [RL17] Host supplies 24 data clocks for an I2C result read.
// [RL18] Acknowledge follows every 8 data bits of an I2C read.
// [RL19] I2C calibration read: write with command, then separate read.
// [RL20] I2C conversion start: address+W, ack, command, ack, STOP.
// [RL21] Host acknowledges read bytes except the last, then sends STOP.
// [RL22] Commands: reset 1E, read 00, conversions 40-48 and 50-58 even.
// [RL23] Calibration commands A0-AE, word address in command bits 3..1.
// [RL24] SPI chip select may rise after command or after execution.
// [RL25] Protocol select low picks SPI, high picks I2C.
module prs_port #(
  parameter int FIFO_DEPTH = `PRS_FIFO_DEPTH
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          SYS_RST,
  input  wire logic                          PROTOCOL_SELECT_PIN,
  input  wire logic                          CHIP_SELECT_N_PIN,
  input  wire logic                          SCLK_PIN,
  input  wire logic                          SERIAL_IN_PIN,
  output logic                               SERIAL_OUT_PIN,
  output logic                               SDA_OUT,
  output logic                               SDA_OE,
  input  wire logic [`PRS_CAL_W*`PRS_CAL_N-1:0] CAL_ROM,
  output logic                               CONV_START,
  output prs_pkg::prs_conv_req_t             CONV_REQ,
  input  wire logic                          CONV_VALID,
  output logic                               CONV_READY,
  input  wire logic [`PRS_ADC_W-1:0]         CONV_DATA,
  output logic                               BUSY
);
  logic [3:0]                 pins;
  logic                       ps;
  logic                       csn;
  logic                       scl;
  logic                       sda;
  logic                       scl_q;
  logic                       sda_q;
  logic                       rise;
  logic                       fall;
  logic                       start_c;
  logic                       stop_c;
  logic                       spi_act;
  logic [7:0]                 rx;
  logic [7:0]                 nb;
  logic [3:0]                 cnt;
  logic                       fresh;
  logic                       resp;
  logic                       rw;
  logic                       cmd_stb;
  logic [7:0]                 cmd;
  prs_pkg::prs_i2c_state_t    st;
  logic                       is_rst;
  logic                       is_rd;
  logic                       is_conv;
  logic                       is_prom;
  logic                       busy;
  logic                       corrupt;
  logic                       done;
  logic                       pop;
  logic                       fifo_ov;
  logic [`PRS_ADC_W-1:0]      fifo_data;
  logic                       res_valid;
  logic [`PRS_ADC_W-1:0]      result;
  logic [`PRS_ADC_W-1:0]      tx;
  logic                       shift;
  logic [`PRS_CAL_W-1:0]      cal [`PRS_CAL_N];

  function automatic logic has_reply(input logic [7:0] c);
    return c == `PRS_CMD_ADC_READ || (c[7:4] == `PRS_PROM_TAG && !c[0]);
  endfunction

  prs_sync #(.W(4)) u_sync (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .d   ({PROTOCOL_SELECT_PIN, CHIP_SELECT_N_PIN, SCLK_PIN, SERIAL_IN_PIN}),
    .q   (pins)
  );

  prs_fifo #(.W(`PRS_ADC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .in_valid  (CONV_VALID),
    .in_ready  (CONV_READY),
    .in_data   (CONV_DATA),
    .out_valid (fifo_ov),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  assign {ps, csn, scl, sda} = pins;
  assign rise    = scl & ~scl_q;
  assign fall    = ~scl & scl_q;
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c  = scl & scl_q & ~sda_q & sda;
  assign spi_act = ~ps & ~csn; // RL25
  assign nb      = {rx[6:0], sda};

  assign is_rst  = cmd == `PRS_CMD_RESET; // RL22
  assign is_rd   = cmd == `PRS_CMD_ADC_READ; // RL22
  assign is_conv = cmd[7:5] == `PRS_CONV_TAG && !cmd[0] &&
                   cmd[3:1] <= `PRS_OSR_MAX; // RL22
  assign is_prom = cmd[7:4] == `PRS_PROM_TAG && !cmd[0]; // RL23

  // Words are only taken while a conversion waits and no command lands.
  assign pop  = busy & ~cmd_stb;
  assign done = pop & fifo_ov;

  // Mode 0 and mode 3 both sample on rising and shift on falling; the
  // falling edge right after a command byte keeps the freshly loaded MSB.
  assign shift = (spi_act & fall & resp & ~fresh) | // RL3
                 (ps && st == prs_pkg::PRS_RBYTE && fall && cnt != 4'h0);

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Serial framing for both protocols.
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx      <= 8'h00;
      cnt     <= 4'h0;
      fresh   <= 1'b0;
      resp    <= 1'b0;
      rw      <= 1'b0;
      cmd_stb <= 1'b0;
      cmd     <= 8'h00;
      st      <= prs_pkg::PRS_IDLE;
    end else begin
      cmd_stb <= 1'b0;
      if (!ps) begin
        st <= prs_pkg::PRS_IDLE;
        if (!spi_act) begin
          cnt   <= 4'h0;
          fresh <= 1'b0;
          resp  <= 1'b0; // RL24
        end else if (rise && !resp) begin
          rx <= nb;
          if (cnt == `PRS_CMD_LAST_BIT) begin
            cnt     <= 4'h0;
            cmd_stb <= 1'b1;
            cmd     <= nb;
            fresh   <= 1'b1;
            resp    <= has_reply(nb);
          end else begin
            cnt <= cnt + 4'h1;
          end
        end else if (fall) begin
          fresh <= 1'b0;
        end
      end else begin
        fresh <= 1'b0;
        resp  <= 1'b0;
        if (start_c) begin
          st  <= prs_pkg::PRS_ADDR; // RL13
          cnt <= 4'h0;
        end else if (stop_c) begin
          st <= prs_pkg::PRS_IDLE; // RL13
        end else begin
          unique case (st)
            prs_pkg::PRS_IDLE, prs_pkg::PRS_WAIT: begin
            end
            prs_pkg::PRS_ADDR: begin
              if (rise) begin
                rx  <= nb;
                cnt <= cnt + 4'h1;
              end else if (fall && cnt == `PRS_BYTE_BITS) begin
                // Reads are refused while a conversion runs.
                if (rx[7:1] == {`PRS_I2C_ADDR_HI, ~csn} &&
                    !(rx[0] && busy)) begin // RL14 RL16
                  st <= prs_pkg::PRS_ACK_ADDR;
                  rw <= rx[0];
                end else begin
                  st <= prs_pkg::PRS_WAIT;
                end
              end
            end
            prs_pkg::PRS_ACK_ADDR: begin
              if (fall) begin
                cnt <= 4'h0;
                st  <= rw ? prs_pkg::PRS_RBYTE : prs_pkg::PRS_WBYTE; // RL19
              end
            end
            prs_pkg::PRS_WBYTE: begin
              if (rise) begin
                rx  <= nb;
                cnt <= cnt + 4'h1;
                if (cnt == `PRS_CMD_LAST_BIT) begin
                  cmd_stb <= 1'b1; // RL15
                  cmd     <= nb;
                end
              end else if (fall && cnt == `PRS_BYTE_BITS) begin
                st <= prs_pkg::PRS_ACK_W;
              end
            end
            prs_pkg::PRS_ACK_W: begin
              if (fall) begin
                cnt <= 4'h0;
                st  <= prs_pkg::PRS_WBYTE;
              end
            end
            prs_pkg::PRS_RBYTE: begin
              if (rise) begin
                cnt <= cnt + 4'h1;
              end else if (fall && cnt == `PRS_BYTE_BITS) begin
                st <= prs_pkg::PRS_ACK_R; // RL18
              end
            end
            prs_pkg::PRS_ACK_R: begin
              if (rise && sda) begin
                st <= prs_pkg::PRS_WAIT;
              end else if (fall) begin
                cnt <= 4'h0;
                st  <= prs_pkg::PRS_RBYTE; // RL18
              end
            end
          endcase
        end
      end
    end
  end

  // Conversion tracking; a second start or an early read spoils the result.
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy    <= 1'b0;
      corrupt <= 1'b0;
    end else if (cmd_stb && is_rst) begin
      busy    <= 1'b0; // RL2
      corrupt <= 1'b0;
    end else if (cmd_stb && is_conv) begin
      busy    <= 1'b1; // RL4 RL16
      corrupt <= busy;
    end else if (cmd_stb && is_rd && busy) begin
      corrupt <= 1'b1; // RL7
    end else if (done) begin
      busy    <= 1'b0;
      corrupt <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CONV_START <= 1'b0;
      CONV_REQ   <= '0;
    end else begin
      CONV_START <= cmd_stb & is_conv; // RL4
      if (cmd_stb && is_conv) begin
        CONV_REQ <= '{temp: cmd[4], oversampling_ratio: cmd[3:1]};
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      res_valid <= 1'b0;
      result    <= '0;
    end else if (cmd_stb && is_rst) begin
      res_valid <= 1'b0;
      result    <= '0;
    end else if (done) begin
      res_valid <= 1'b1;
      result    <= corrupt ? ~fifo_data : fifo_data; // RL7
    end else if (cmd_stb && is_rd) begin
      res_valid <= 1'b0; // RL6
    end
  end

  // Calibration words are copied from the storage array on a reset command.
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < `PRS_CAL_N; i++) begin
        cal[i] <= '0;
      end
    end else if (cmd_stb && is_rst) begin
      for (int i = 0; i < `PRS_CAL_N; i++) begin
        cal[i] <= CAL_ROM[i*`PRS_CAL_W +: `PRS_CAL_W]; // RL10 RL11
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx <= '0;
    end else if (cmd_stb && is_rd) begin
      tx <= (res_valid && !busy) ? result : '0; // RL5 RL6 RL7
    end else if (cmd_stb && is_prom) begin
      tx <= {cal[cmd[3:1]], `PRS_PAD_BYTE}; // RL12 RL23
    end else if (cmd_stb && is_rst) begin
      tx <= '0;
    end else if (shift) begin
      tx <= {tx[`PRS_ADC_W-2:0], 1'b0}; // RL5 RL12
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SERIAL_OUT_PIN <= 1'b0;
      SDA_OE         <= 1'b0;
    end else begin
      SERIAL_OUT_PIN <= spi_act & tx[`PRS_ADC_W-1]; // RL5
      SDA_OE <= ps && (st == prs_pkg::PRS_ACK_ADDR ||
                       st == prs_pkg::PRS_ACK_W ||
                       (st == prs_pkg::PRS_RBYTE && !tx[`PRS_ADC_W-1]));
    end
  end

  assign SDA_OUT = 1'b0;
  assign BUSY    = busy;

  a_conv_start_fires: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_conv |=> CONV_START ##1 !CONV_START) // RL4
    else $error("conversion start pulse wrong");
  a_conv_stays_busy: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_conv |=> busy) // RL16
    else $error("busy not set by conversion command");
  a_reset_idles: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_rst |=> !busy && !res_valid && tx == '0) // RL2
    else $error("reset command left state behind");
  a_read_busy_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_rd && busy |=> tx == '0 && corrupt) // RL7
    else $error("read during conversion not zero");
  a_read_empty_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_rd && !res_valid |=> tx == '0) // RL6
    else $error("read without result not zero");
  a_read_consumes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_rd && !done |=> !res_valid) // RL6
    else $error("result still valid after read");
  a_prom_word: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    cmd_stb && is_prom |=> tx[`PRS_ADC_W-1 -: `PRS_CAL_W] == cal[cmd[3:1]]
      && tx[7:0] == `PRS_PAD_BYTE) // RL12
    else $error("calibration word not loaded");
  a_addr_match: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(st == prs_pkg::PRS_ACK_ADDR) |->
      rx[7:1] == {`PRS_I2C_ADDR_HI, ~csn}) // RL14
    else $error("acknowledged a foreign address");
endmodule

// ===== hw/prs_sync.sv
`timescale 1ns/1ns
module prs_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== pkg/prs_cfg.svh
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// Command byte codes and fields.
`define PRS_CMD_RESET    8'h1e
`define PRS_CMD_ADC_READ 8'h00
`define PRS_CONV_TAG     3'h2
`define PRS_PROM_TAG     4'ha
`define PRS_OSR_MAX      3'h4
`define PRS_CMD_LAST_BIT 4'h7

// Upper six bits of the serial bus address.
`define PRS_I2C_ADDR_HI  6'h3b
`define PRS_BYTE_BITS    4'h8

// Data widths and storage sizes.
`define PRS_ADC_W        24
`define PRS_CAL_W        16
`define PRS_CAL_N        8
`define PRS_FIFO_DEPTH   32
`define PRS_PAD_BYTE     8'h00

`endif

// ===== pkg/prs_pkg.sv
package prs_pkg;

  typedef struct packed {
    logic       temp;
    logic [2:0] oversampling_ratio;
  } prs_conv_req_t;

  typedef enum logic [2:0] {
    PRS_IDLE,
    PRS_ADDR,
    PRS_ACK_ADDR,
    PRS_WBYTE,
    PRS_ACK_W,
    PRS_RBYTE,
    PRS_ACK_R,
    PRS_WAIT
  } prs_i2c_state_t;

endpackage
